// ===== core/bwte_core.sv
// Word recognizer trigger expander: samples a probe bus, matches the address,
// delays the trigger and forwards one selected byte.
// Assumes probe pins are asynchronous to core_clk_in and that the probe clock
// is slow enough (several core cycles per phase) to be edge-detected here.
// Limitation: each probe clock phase must span at least three core cycles,
// or an edge can be lost in the synchronisers.
`default_nettype none
`include "bwte_defs.svh"

// Overview of operation
// - All sixteen sampled address bits are compared with the preset value; equality fires a match.
// - Exactly one of data byte, upper address byte or lower address byte goes to the byte output.
// - Qualifier mode low or high demands that level on the qualifier pin; don't-care ignores it.
// - With the write strobe on the qualifier pin, only cycles writing the matched address fire.
// - The delay counts either qualified clocks or further triggers and fires when exhausted.
// - Delay preset covers 0 to 999, and zero passes the trigger straight through.
// - With clock qualification on, edges count only while the clock qualifier is high.
// - Address triggering is either off or synchronous to qualified sampling edges.
module bwte_core
  import bwte_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    probe_clk_in,
  input  wire logic [`BWTE_ADDR_W-1:0] probe_addr_in,
  input  wire logic [`BWTE_DATA_W-1:0] probe_data_in,
  input  wire logic                    trig_qual_in,
  input  wire logic                    valid_address_flag_in,
  input  wire bwte_cfg_s               cfg_in,
  output var  logic [`BWTE_DATA_W-1:0] mux_byte_out,
  output var  logic                    match_out,
  output var  logic                    trigger_out,
  output var  logic [`BWTE_DLY_W-1:0]  dly_count_out
);

  // ************************************************
  // Input synchronisers
  // ************************************************
  bwte_probe_s probe_now;
  bwte_probe_s probe_meta;
  bwte_probe_s probe_sync;
  logic        pclk_meta;
  logic        pclk_sync;
  logic        pclk_prev;
  logic [`BWTE_WARM_W-1:0] warm;

  assign probe_now = '{addr: probe_addr_in, data: probe_data_in,
                       trig_qual: trig_qual_in,
                       valid_address_flag: valid_address_flag_in};

  // Two stages on every bus pin; first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      probe_meta <= '0;
      probe_sync <= '0;
    end else begin
      probe_meta <= probe_now;
      probe_sync <= probe_meta;
    end
  end

  // Probe clock gets the same two stages plus one history stage, so an edge
  // is seen in the very cycle its bus word leaves the second stage
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pclk_meta <= 1'b0;
      pclk_sync <= 1'b0;
      pclk_prev <= 1'b0;
    end else begin
      pclk_meta <= probe_clk_in;
      pclk_sync <= pclk_meta;
      pclk_prev <= pclk_sync;
    end
  end

  // History valid flag. Reset leaves zeros in the edge detector; if the probe
  // clock idles high, comparing those zeros with the first real sample would
  // fake a rising edge, so no edge counts until the history is real
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warm <= '0;
    end else begin
      warm <= {warm[`BWTE_WARM_W-2:0], 1'b1};
    end
  end

  // ************************************************
  // Sampling edge and qualifiers
  // ************************************************
  logic sample_edge;
  logic clk_ok;
  logic qual_ok;
  logic qual_edge;
  logic hit;

  // Qualifier check used once, by the match path; the delay path sees it only through matches
  function automatic logic qual_pass(input logic [1:0] mode, input logic lvl);
    case (mode)
      `BWTE_QUAL_LOW:  qual_pass = !lvl;
      `BWTE_QUAL_HIGH: qual_pass = lvl;
      default:         qual_pass = 1'b1;
    endcase
  endfunction

  // Data and probe clock arrive through equal sync depth, so both are aligned
  assign sample_edge = warm[`BWTE_WARM_W-1]
                    && (cfg_in.edge_falling ? (pclk_prev && !pclk_sync)
                                            : (!pclk_prev && pclk_sync));
  // A low clock qualifier drops the whole edge, display update included
  assign clk_ok    = !cfg_in.clk_qual_en || probe_sync.valid_address_flag;
  assign qual_edge = sample_edge && clk_ok;
  // Qualifier level comes from the same synchronised word as the address
  assign qual_ok   = qual_pass(cfg_in.trig_qual_mode, probe_sync.trig_qual);
  // Off mode disables address triggering entirely
  assign hit = cfg_in.trig_sync && qual_edge && qual_ok
            && (probe_sync.addr == cfg_in.match_addr);

  // ************************************************
  // Display multiplexer
  // ************************************************
  // Latched on qualified edges so the analyzer sees a steady byte
  // The display follows accepted edges even while address triggering is off
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mux_byte_out <= '0;
    end else if (qual_edge) begin
      case (cfg_in.mux_sel)
        `BWTE_MUX_AHI: mux_byte_out <= probe_sync.addr[`BWTE_ADDR_W-1 -: `BWTE_DATA_W];
        `BWTE_MUX_ALO: mux_byte_out <= probe_sync.addr[`BWTE_DATA_W-1:0];
        default:       mux_byte_out <= probe_sync.data;
      endcase
    end
  end

  // Raw match pulse for observers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_out <= 1'b0;
    end else begin
      match_out <= hit;
    end
  end

  // ************************************************
  // Delay counter
  // ************************************************
  bwte_state_e            state;
  logic [`BWTE_DLY_W-1:0] count;
  logic [`BWTE_DLY_W-1:0] preset_clip;
  logic                   dec_evt;
  logic                   preset_zero;
  logic                   arm_now;
  logic                   pass_now;
  logic                   last_step;

  // Presets above 999 are clipped; the dials cannot go higher
  assign preset_clip = (cfg_in.dly_preset > `BWTE_DLY_MAX) ? `BWTE_DLY_MAX
                                                          : cfg_in.dly_preset;
  assign dec_evt = cfg_in.dly_by_trigger ? hit : qual_edge;
  assign preset_zero = (preset_clip == `BWTE_DLY_ZERO);
  // A match only arms from idle; while counting it is just a decrement event
  assign arm_now   = (state == BWTE_IDLE) && hit && !preset_zero;
  assign pass_now  = (state == BWTE_IDLE) && hit && preset_zero;
  assign last_step = (state == BWTE_COUNT) && dec_evt
                  && (count == `BWTE_DLY_ONE);

  // Idle or counting; leaving on the last step frees the next match to re-arm
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= BWTE_IDLE;
    end else begin
      case (state)
        BWTE_IDLE: begin
          if (arm_now) begin
            state <= BWTE_COUNT;
          end
        end
        BWTE_COUNT: begin
          if (last_step) begin
            state <= BWTE_IDLE;
          end
        end
        default: state <= BWTE_IDLE;
      endcase
    end
  end

  // Loaded only when arming, so a repeat match in trigger mode never restarts
  // the delay; in clock mode the same match simply counts as one more clock
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= `BWTE_DLY_ZERO;
    end else if (arm_now) begin
      count <= preset_clip;
    end else if ((state == BWTE_COUNT) && dec_evt) begin
      count <= count - `BWTE_DLY_ONE;
    end
  end

  // One-cycle trigger, straight through for a zero preset, else on the last step
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trigger_out <= 1'b0;
    end else begin
      trigger_out <= pass_now || last_step;
    end
  end

  // Remaining count shown for the operator
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dly_count_out <= `BWTE_DLY_ZERO;
    end else begin
      dly_count_out <= count;
    end
  end

endmodule : bwte_core

`default_nettype wire

// ===== core/bwte_defs.svh
// Constants for the bus word trigger expander: field widths, encodings, counts.
// Assumes inclusion by bare name from the package and the design module.
`ifndef BWTE_DEFS_SVH
`define BWTE_DEFS_SVH

`define BWTE_ADDR_W     16
`define BWTE_DATA_W     8
`define BWTE_DLY_W      10
`define BWTE_DLY_MAX    10'h3E7
`define BWTE_DLY_ZERO   10'h000
`define BWTE_DLY_ONE    10'h001
`define BWTE_WARM_W     3
`define BWTE_QUAL_LOW   2'h0
`define BWTE_QUAL_HIGH  2'h1
`define BWTE_QUAL_ANY   2'h2
`define BWTE_MUX_DATA   2'h0
`define BWTE_MUX_AHI    2'h1
`define BWTE_MUX_ALO    2'h2

`endif

// ===== core/bwte_pkg.sv
// Types shared by the bus word trigger expander.
// Assumes bwte_defs.svh is on the include path.
`default_nettype none
`include "bwte_defs.svh"

package bwte_pkg;

  // Sampled probe word
  typedef struct packed {
    logic [`BWTE_ADDR_W-1:0] addr;
    logic [`BWTE_DATA_W-1:0] data;
    logic                    trig_qual;
    logic                    valid_address_flag;
  } bwte_probe_s;

  // Front-panel style settings
  typedef struct packed {
    logic [`BWTE_ADDR_W-1:0] match_addr;
    logic [1:0]              trig_qual_mode;
    logic                    clk_qual_en;
    logic                    dly_by_trigger;
    logic [`BWTE_DLY_W-1:0]  dly_preset;
    logic                    trig_sync;
    logic [1:0]              mux_sel;
    logic                    edge_falling;
  } bwte_cfg_s;

  typedef enum logic [1:0] {
    BWTE_IDLE  = 2'b00,
    BWTE_COUNT = 2'b01
  } bwte_state_e;

endpackage : bwte_pkg

`default_nettype wire

// ===== test/bwte_core_checker.sv
// Port checker for bwte_core, bound below.
// Assumes probe phases of three or more core cycles.
`default_nettype none
module bwte_core_checker
  import bwte_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] probe_addr_in,
  input wire logic        trig_qual_in,
  input wire logic        valid_address_flag_in,
  input wire bwte_cfg_s   cfg_in,
  input wire logic [7:0]  mux_byte_out,
  input wire logic        match_out,
  input wire logic        trigger_out,
  input wire logic [9:0]  dly_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Pins reach the match three cycles late; a match rests two cycles after
  sequence s_quiet; ##1 !match_out [*2]; endsequence
  a_match_addr: assert property (match_out |-> $past(probe_addr_in, 3) == cfg_in.match_addr)
    else $error("bad match address");
  a_match_pulse: assert property (match_out |-> s_quiet)
    else $error("match too long");
  a_hi_byte: assert property (match_out && cfg_in.mux_sel == 2'h1
    |-> mux_byte_out == cfg_in.match_addr[15:8])
    else $error("bad high byte");
  a_qual_low: assert property (match_out && cfg_in.trig_qual_mode == 2'h0
    |-> !$past(trig_qual_in, 3))
    else $error("bad qualifier");
  a_flag_gate: assert property (match_out && cfg_in.clk_qual_en
    |-> $past(valid_address_flag_in, 3))
    else $error("edge not gated");
  a_off_quiet: assert property (!$past(cfg_in.trig_sync) |-> !match_out)
    else $error("match while off");
  a_zero_pass: assert property (match_out && cfg_in.dly_preset == 10'h000 |-> trigger_out)
    else $error("zero delay held");
  a_count_max: assert property (dly_count_out <= 10'h3E7)
    else $error("count too big");
endmodule // bwte_core_checker
bind bwte_core bwte_core_checker u_chk (.core_clk_in, .rst_n_in, .probe_addr_in, .trig_qual_in,
  .valid_address_flag_in, .cfg_in, .mux_byte_out, .match_out, .trigger_out, .dly_count_out);
`default_nettype wire

// ===== test/bwte_core_tb_top.sv
// Bench for bwte_core: row table, then delay and reset cases.
// Assumes the probe model paces the probe clock from core_clk_in.
`default_nettype none
module bwte_core_tb_top import bwte_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] tq; logic cq, sy; logic [1:0] mx; logic fl;
    logic [15:0] a; logic q, f, m; logic [7:0] b;} bwte_row_s;
  localparam logic [15:0] MA = 16'hA5C3;
  localparam logic [7:0]  DT = 8'h5E;
  logic        core_clk_in, rst_n_in, go, busy, pclk, match_out, trigger_out;
  logic [7:0]  mux_byte_out;
  logic [9:0]  dly_count_out;
  bwte_cfg_s   cfg;
  bwte_probe_s word, pins;
  int          error_cnt, samples_checked, mcnt, tcnt, m0, t0;
  bwte_row_s   rw [10] = '{'{2,0,1,1,0,MA,0,0,1,8'hA5}, '{2,0,1,2,1,MA,0,0,1,8'hC3},
    '{2,0,1,3,0,MA,0,0,1,DT}, '{2,0,1,0,1,16'h25C2,0,0,0,DT}, '{0,0,1,0,0,MA,0,1,1,DT},
    '{0,0,1,0,0,MA,1,1,0,DT}, '{1,0,1,0,0,MA,1,0,1,DT}, '{2,1,1,0,0,MA,0,1,1,DT},
    '{2,1,1,1,0,MA,0,0,0,DT}, '{3,0,0,0,0,MA,0,1,0,DT}};
  bwte_core DUT (.core_clk_in, .rst_n_in, .probe_clk_in(pclk), .probe_addr_in(pins.addr),
    .probe_data_in(pins.data), .trig_qual_in(pins.trig_qual), .cfg_in(cfg),
    .valid_address_flag_in(pins.valid_address_flag), .mux_byte_out, .match_out,
    .trigger_out, .dly_count_out);
  bwte_probe_model PM (.clk_in(core_clk_in), .go_in(go), .fall_in(cfg.edge_falling),
    .word_in(word), .busy_out(busy), .pclk_out(pclk), .pins_out(pins));
  task automatic check(string nm, logic [9:0] e, logic [9:0] g);
    samples_checked++;
    if (e !== g) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One probe pulse; bounded wait for the model to finish
  task automatic step(logic [15:0] a, logic q, logic f);
    int n;
    word <= '{a, DT, q, f};
    go <= 1'h1;
    @(posedge core_clk_in);
    go <= 1'h0;
    for (n = 0; n < 40 && (n < 2 || busy !== 1'h0); n++) @(posedge core_clk_in);
    if (n == 40) begin
      error_cnt++;
      final_report();
    end
  endtask
  always @(posedge core_clk_in) begin
    mcnt += (match_out === 1'h1);
    tcnt += (trigger_out === 1'h1);
  end
  initial begin
    core_clk_in = 1'h0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    {rst_n_in, go, word, error_cnt, samples_checked, mcnt, tcnt} = '0;
    cfg = '{MA, 2'h2, 1'h0, 1'h0, 10'h000, 1'h1, 2'h0, 1'h0};
    repeat (8) @(posedge core_clk_in);
    check("reset", 10'h000, {match_out, trigger_out, mux_byte_out});
    rst_n_in <= 1'h1;
    foreach (rw[i]) begin
      m0 = mcnt;
      t0 = tcnt;
      cfg <= '{MA, rw[i].tq, rw[i].cq, 1'h0, 10'h000, rw[i].sy, rw[i].mx, rw[i].fl};
      step(rw[i].a, rw[i].q, rw[i].f);
      check("match", 10'(rw[i].m), 10'(mcnt - m0));
      check("trigger", 10'(rw[i].m), 10'(tcnt - t0));
      check("byte", 10'(rw[i].b), 10'(mux_byte_out));
      $display("row %0d done", i);
    end
    // Clock delay of two, then trigger delay of two, then clipped preset
    t0 = tcnt;
    cfg.trig_sync  <= 1'h1;
    cfg.dly_preset <= 10'h002;
    for (int k = 0; k < 7; k++) begin
      if (k == 3) cfg.dly_by_trigger <= 1'h1;
      step((k == 2 || k == 4) ? 16'h0000 : MA, 1'h0, 1'h0);
      check("delay", 10'((k > 1) + (k > 5)), 10'(tcnt - t0));
    end
    cfg.dly_preset <= 10'h3FF;
    step(MA, 1'h0, 1'h0);
    check("count", 10'h3E7, dly_count_out);
    $display("delay cases done");
    rst_n_in <= 1'h0;
    @(posedge core_clk_in);
    check("reset", 10'h000, dly_count_out);
    $display("reset case done");
    final_report();
  end
endmodule // bwte_core_tb_top
`default_nettype wire

// ===== test/bwte_probe_model.sv
// Probe-side model: one probe clock pulse per request.
// Assumes requests come only while busy_out is low.
`default_nettype none
module bwte_probe_model
  import bwte_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic        fall_in,
  input  wire bwte_probe_s word_in,
  output var  logic        busy_out,
  output var  logic        pclk_out,
  output var  bwte_probe_s pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    busy_out = 1'h0;
    pclk_out = 1'h0;
    pins_out = '0;
  end
  // Lines set before the edge, held after it, then scrambled
  always @(posedge clk_in) if (go_in) begin
    busy_out <= 1'h1;
    pclk_out <= fall_in;
    pins_out <= word_in;
    repeat (4) @(posedge clk_in);
    pclk_out <= !fall_in;
    repeat (6) @(posedge clk_in);
    pclk_out <= fall_in;
    pins_out <= ~word_in;
    repeat (6) @(posedge clk_in);
    busy_out <= 1'h0;
  end
endmodule // bwte_probe_model
`default_nettype wire
